// ---- fllt_tuner.sv ----
/*
 * loop tuner core: open/closed loop, two-stage lock, drift tracking, flags.
 * assumes ref_tick_in, sof_tick_in and out_tick_in are one-cycle pulses already in the sys_clk_in domain:
 * one per reference period (generic clock on ref_tick_in, usb frame on sof_tick_in) and one per output clock edge group.
 */
// Chosen here: the address-and-strobe port and the placing of the registers.
`timescale 1ns/100ps
`default_nettype none
`include "fllt_params.svh"

module fllt_tuner
	import fllt_pkg::*;
#(
	parameter int REF_STOP_LOG2 = `FLLT_REF_STOP_LOG2
) (
	input  wire logic sys_clk_in,
	input  wire logic resetn_in,
	input  wire logic clk_en_in,
	input  wire logic ref_tick_in,
	input  wire logic sof_tick_in,
	input  wire logic out_tick_in,
	output logic      ref_stop_irq_out,
	fllt_if.tuner     lnk
);
	import fllt_pkg::*;

	typedef struct packed {
		fllt_stage_t                stage;
		logic [`FLLT_COARSE_W-1:0]  coarse;
		logic [`FLLT_FINE_W-1:0]    fine;
		logic [`FLLT_MUL_W-1:0]     meas;
		logic [`FLLT_DIFF_W-1:0]    diff;
		logic [`FLLT_CNT_W-1:0]     stop_cnt;
		logic [3:0]                 rdy_cnt;
		logic                       chill;
		logic                       rdy, lockc, lockf, oob, rcs, irq, rcs_irq;
	} fllt_tst_t;

	fllt_tst_t st_ff, nxt_st;
	fllt_cfg_t c;
	logic                   tick;
	logic                   closed;
	logic [`FLLT_DIFF_W-1:0] err;
	logic [`FLLT_DIFF_W-1:0] aerr;
	logic [`FLLT_DIFF_W-1:0] ftol;
	logic [`FLLT_FINE_W:0]  fsum;
	logic [`FLLT_FINE_W:0]  fstep;
	logic [`FLLT_COARSE_W:0] csum;

	assign c = lnk.cfg;
	// the frame pulse replaces the generic reference outright
	assign tick = c.usb_recovery_mode ? sof_tick_in : ref_tick_in;
	// dropping the enable also falls back to open loop
	assign closed = c.loop_enable & c.closed_loop_select;

	always_comb begin
		nxt_st = st_ff;
		nxt_st.rcs_irq = 1'b0;
		err = st_ff.meas - c.multiply_factor;
		aerr = err[`FLLT_DIFF_W-1] ? (~err + 16'h1) : err;
		ftol = c.quick_lock_disable ? `FLLT_FINE_TOL : `FLLT_QL_FINE_TOL;
		// usb mode always uses the relaxed window
		if (c.usb_recovery_mode) ftol = `FLLT_QL_FINE_TOL;
		// step clipped to the programmed maximum, trading lock time for overshoot
		fstep = (aerr > {8'h0, c.fine_max_step}) ? {3'h0, c.fine_max_step}
			: aerr[`FLLT_FINE_W:0];
		fsum = err[`FLLT_DIFF_W-1] ? ({1'b0, st_ff.fine} + fstep)
			: ({1'b0, st_ff.fine} - fstep);
		// a carry out of csum means the coarse range is used up
		csum = err[`FLLT_DIFF_W-1] ? ({1'b0, st_ff.coarse} + {2'h0, c.coarse_max_step})
			: ({1'b0, st_ff.coarse} - {2'h0, c.coarse_max_step});
		// ready after a short settle once enabled
		if (!c.loop_enable) begin
			nxt_st.rdy_cnt = 4'h0;
			nxt_st.rdy = 1'b0;
		end else if (st_ff.rdy_cnt != `FLLT_READY_CYCLES) begin
			nxt_st.rdy_cnt = st_ff.rdy_cnt + 4'h1;
		end else begin
			nxt_st.rdy = 1'b1;
		end
		// output edge count per reference period; saturating stop watch
		if (out_tick_in && st_ff.meas != 16'hffff) nxt_st.meas = st_ff.meas + 16'h1;
		if (tick) begin
			nxt_st.stop_cnt = '0;
			nxt_st.rcs = 1'b0;
		end else if (closed && !st_ff.stop_cnt[REF_STOP_LOG2-1]) begin
			nxt_st.stop_cnt = st_ff.stop_cnt + 17'h1;
		end else if (closed) begin
			nxt_st.rcs = 1'b1;
		end
		// one pulse on the 0->1 edge only; the level is carried by irq
		nxt_st.rcs_irq = nxt_st.rcs & ~st_ff.rcs & c.ie_refstop;
		// clear first so that an overflow in the same cycle wins
		if (lnk.flag_clear) nxt_st.oob = 1'b0;
		if (!closed) begin
			nxt_st.stage = FLLT_OPEN;
			nxt_st.lockc = 1'b0;
			nxt_st.lockf = 1'b0;
			if (lnk.value_write) begin
				nxt_st.coarse = c.coarse_tuning_value;
				nxt_st.fine = c.fine_tuning_value;
			end
		end else if (st_ff.stage == FLLT_OPEN) begin
			// coarse start point is what is held
			if (c.usb_recovery_mode || c.coarse_lock_bypass) begin
				nxt_st.stage = FLLT_FINE;
				nxt_st.lockc = 1'b1;
			end else begin
				nxt_st.stage = FLLT_COARSE;
			end
			nxt_st.meas = '0;
			nxt_st.chill = 1'b1;
		end else if (tick && !st_ff.rcs) begin
			// stopped reference freezes tuning, as in open loop
			nxt_st.meas = '0;
			nxt_st.chill = ~st_ff.chill & ~c.chill_cycle_disable;
			// chill periods are skipped: tuning just applied has not settled yet
			if (!st_ff.chill || c.chill_cycle_disable) begin
				nxt_st.diff = err;
				case (st_ff.stage)
					FLLT_COARSE: begin
						if (aerr <= `FLLT_COARSE_TOL || csum[`FLLT_COARSE_W]) begin
							nxt_st.stage = FLLT_FINE;
							nxt_st.lockc = 1'b1;
						end else begin
							nxt_st.coarse = csum[`FLLT_COARSE_W-1:0];
						end
					end
					// track reuses the fine adder so drift follow-up costs no extra logic
					FLLT_FINE, FLLT_TRACK: begin
						if (st_ff.stage == FLLT_FINE && aerr <= ftol) begin
							nxt_st.stage = FLLT_TRACK;
							nxt_st.lockf = 1'b1;
						end else if (st_ff.stage == FLLT_TRACK && c.stable_frequency_hold
							&& !c.usb_recovery_mode) begin
							nxt_st.fine = st_ff.fine;
						end else if (c.usb_recovery_mode && st_ff.stage == FLLT_TRACK
							&& (aerr & `FLLT_JITTER_MASK) == 16'h0) begin
							nxt_st.fine = st_ff.fine;
						end else if (fsum[`FLLT_FINE_W]) begin
							nxt_st.oob = 1'b1;
						end else begin
							nxt_st.fine = fsum[`FLLT_FINE_W-1:0];
						end
					end
					default: nxt_st.stage = FLLT_OPEN;
				endcase
			end
		end else if (tick) begin
			// restart tick after a stop: the count spans no full period, only restart it
			nxt_st.meas = '0;
		end
		if (closed && tick && st_ff.stage != FLLT_OPEN && !st_ff.rcs && fsum[`FLLT_FINE_W]
			&& st_ff.stage != FLLT_COARSE && !(st_ff.chill && !c.chill_cycle_disable))
			nxt_st.oob = nxt_st.oob | (nxt_st.fine == st_ff.fine && !nxt_st.lockf);
		// irq is a level, recomputed each cycle from the enabled lock and stop flags
		nxt_st.irq = (nxt_st.lockc & c.ie_coarse) | (nxt_st.lockf & c.ie_fine)
			| (nxt_st.rcs & c.ie_refstop);
	end

	always_ff @(posedge sys_clk_in or negedge resetn_in) begin
		if (!resetn_in) begin
			st_ff <= '0;
			st_ff.coarse <= `FLLT_COARSE_RST;
			st_ff.fine <= `FLLT_FINE_RST;
		end else if (clk_en_in) begin
			st_ff <= nxt_st;
		end
	end

	// tuning values are driven only by the tuner, read-only in closed loop
	assign lnk.coarse_tuning_value    = st_ff.coarse;
	assign lnk.fine_tuning_value      = st_ff.fine;
	assign lnk.ratio_difference       = st_ff.diff;
	assign lnk.loop_ready_flag        = st_ff.rdy;
	assign lnk.coarse_locked_flag     = st_ff.lockc;
	assign lnk.fine_locked_flag       = st_ff.lockf;
	assign lnk.out_of_bounds_flag     = st_ff.oob;
	assign lnk.reference_stopped_flag = st_ff.rcs;
	assign lnk.irq                    = st_ff.irq;
	assign ref_stop_irq_out           = st_ff.rcs_irq;
endmodule

`default_nettype wire

// ---- fllt_params.svh ----
/*
 * constants for the frequency locked loop tuner: widths, reset values, timing counts.
 * assumes inclusion by bare name from the package and both end modules.
 */
`ifndef FLLT_PARAMS_SVH
`define FLLT_PARAMS_SVH

`define FLLT_COARSE_W      6
`define FLLT_FINE_W        10
`define FLLT_MUL_W         16
`define FLLT_CSTEP_W       5
`define FLLT_FSTEP_W       8
`define FLLT_DIFF_W        16
`define FLLT_CNT_W         17
`define FLLT_COARSE_RST    6'h1f
`define FLLT_FINE_RST      10'h200
`define FLLT_FINE_MAX      10'h3ff
`define FLLT_USB_MUL       16'hbb80
`define FLLT_REF_STOP_LOG2 17
`define FLLT_READY_CYCLES  4'h8
`define FLLT_COARSE_TOL    16'h0010
`define FLLT_FINE_TOL      16'h0001
`define FLLT_QL_FINE_TOL   16'h0004
`define FLLT_JITTER_MASK   16'hfffe

`endif

// ---- fllt_pkg.sv ----
/*
 * types shared by the two ends of the frequency locked loop tuner.
 * assumes fllt_params.svh is on the include path.
 */
`include "fllt_params.svh"

package fllt_pkg;
	typedef enum logic [1:0] {
		FLLT_OPEN,
		FLLT_COARSE,
		FLLT_FINE,
		FLLT_TRACK
	} fllt_stage_t;

	typedef struct packed {
		logic                        closed_loop_select;
		logic                        coarse_lock_bypass;
		logic                        stable_frequency_hold;
		logic                        chill_cycle_disable;
		logic                        quick_lock_disable;
		logic                        usb_recovery_mode;
		logic                        loop_enable;
		logic [`FLLT_COARSE_W-1:0]   coarse_tuning_value;
		logic [`FLLT_FINE_W-1:0]     fine_tuning_value;
		logic [`FLLT_MUL_W-1:0]      multiply_factor;
		logic [`FLLT_CSTEP_W-1:0]    coarse_max_step;
		logic [`FLLT_FSTEP_W-1:0]    fine_max_step;
		logic                        ie_coarse;
		logic                        ie_fine;
		logic                        ie_refstop;
	} fllt_cfg_t;
endpackage

// ---- fllt_if.sv ----
/*
 * link between the software-side controller and the loop tuner core.
 * assumes one shared clock; the controller drives cfg, the tuner drives status.
 */
`timescale 1ns/100ps
`default_nettype none
`include "fllt_params.svh"

interface fllt_if;
	import fllt_pkg::*;
	fllt_cfg_t                  cfg;
	logic                       value_write;
	logic                       flag_clear;
	logic [`FLLT_COARSE_W-1:0]  coarse_tuning_value;
	logic [`FLLT_FINE_W-1:0]    fine_tuning_value;
	logic [`FLLT_DIFF_W-1:0]    ratio_difference;
	logic                       loop_ready_flag;
	logic                       coarse_locked_flag;
	logic                       fine_locked_flag;
	logic                       out_of_bounds_flag;
	logic                       reference_stopped_flag;
	logic                       irq;

	modport ctrl (output cfg, output value_write, output flag_clear,
		input coarse_tuning_value, input fine_tuning_value, input ratio_difference,
		input loop_ready_flag, input coarse_locked_flag, input fine_locked_flag,
		input out_of_bounds_flag, input reference_stopped_flag, input irq);
	modport tuner (input cfg, input value_write, input flag_clear,
		output coarse_tuning_value, output fine_tuning_value, output ratio_difference,
		output loop_ready_flag, output coarse_locked_flag, output fine_locked_flag,
		output out_of_bounds_flag, output reference_stopped_flag, output irq);
endinterface

`default_nettype wire

// ---- fllt_ctrl.sv ----
/*
 * software-facing end: register port, holds configuration, reads tuner status.
 * assumes a single-cycle strobe master; read data valid the cycle after the strobe.
 */
`timescale 1ns/100ps
`default_nettype none
`include "fllt_params.svh"

module fllt_ctrl
	import fllt_pkg::*;
(
	input  wire logic        sys_clk_in,
	input  wire logic        resetn_in,
	input  wire logic        clk_en_in,
	input  wire logic [3:0]  addr_in,
	input  wire logic [31:0] wdata_in,
	input  wire logic        wr_in,
	input  wire logic        rd_in,
	output logic      [31:0] rdata_out,
	fllt_if.ctrl             lnk
);
	import fllt_pkg::*;

	localparam logic [3:0] A_CTRL = 4'h0;
	localparam logic [3:0] A_VAL  = 4'h1;
	localparam logic [3:0] A_MUL  = 4'h2;
	localparam logic [3:0] A_STAT = 4'h3;
	localparam logic [3:0] A_IEN  = 4'h4;

	typedef struct packed {
		fllt_cfg_t   cfg;
		logic        value_write;
		logic        flag_clear;
		logic [31:0] rdata;
	} fllt_cst_t;

	fllt_cst_t st_ff, nxt_st;

	always_comb begin
		nxt_st = st_ff;
		nxt_st.value_write = 1'b0;
		nxt_st.flag_clear = 1'b0;
		nxt_st.rdata = 32'h0;
		if (wr_in) begin
			case (addr_in)
				A_CTRL: begin
					nxt_st.cfg.loop_enable           = wdata_in[0];
					nxt_st.cfg.closed_loop_select    = wdata_in[1];
					nxt_st.cfg.stable_frequency_hold = wdata_in[2];
					nxt_st.cfg.coarse_lock_bypass    = wdata_in[3];
					nxt_st.cfg.chill_cycle_disable   = wdata_in[4];
					nxt_st.cfg.quick_lock_disable    = wdata_in[5];
					nxt_st.cfg.usb_recovery_mode     = wdata_in[6];
				end
				A_VAL: begin
					nxt_st.cfg.fine_tuning_value   = wdata_in[`FLLT_FINE_W-1:0];
					nxt_st.cfg.coarse_tuning_value = wdata_in[`FLLT_COARSE_W+9:10];
					nxt_st.value_write = 1'b1;
				end
				A_MUL: begin
					nxt_st.cfg.multiply_factor = wdata_in[15:0];
					nxt_st.cfg.fine_max_step   = wdata_in[`FLLT_FSTEP_W+15:16];
					nxt_st.cfg.coarse_max_step = wdata_in[`FLLT_CSTEP_W+25:26];
				end
				A_STAT: nxt_st.flag_clear = wdata_in[0];
				A_IEN: begin
					nxt_st.cfg.ie_coarse  = wdata_in[0];
					nxt_st.cfg.ie_fine    = wdata_in[1];
					nxt_st.cfg.ie_refstop = wdata_in[2];
				end
				default: ;
			endcase
		end
		if (rd_in) begin
			case (addr_in)
				A_CTRL: nxt_st.rdata = {25'h0, st_ff.cfg.usb_recovery_mode,
					st_ff.cfg.quick_lock_disable, st_ff.cfg.chill_cycle_disable,
					st_ff.cfg.coarse_lock_bypass, st_ff.cfg.stable_frequency_hold,
					st_ff.cfg.closed_loop_select, st_ff.cfg.loop_enable};
				A_VAL:  nxt_st.rdata = {lnk.ratio_difference, lnk.coarse_tuning_value,
					lnk.fine_tuning_value};
				A_MUL:  nxt_st.rdata = {1'b0, st_ff.cfg.coarse_max_step, 2'h0,
					st_ff.cfg.fine_max_step, st_ff.cfg.multiply_factor};
				A_STAT: nxt_st.rdata = {26'h0, lnk.irq, lnk.reference_stopped_flag,
					lnk.out_of_bounds_flag, lnk.fine_locked_flag,
					lnk.coarse_locked_flag, lnk.loop_ready_flag};
				A_IEN:  nxt_st.rdata = {29'h0, st_ff.cfg.ie_refstop,
					st_ff.cfg.ie_fine, st_ff.cfg.ie_coarse};
				default: nxt_st.rdata = 32'h0;
			endcase
		end
	end

	always_ff @(posedge sys_clk_in or negedge resetn_in) begin
		if (!resetn_in) begin
			st_ff <= '0;
			st_ff.cfg.coarse_tuning_value <= `FLLT_COARSE_RST;
			st_ff.cfg.fine_tuning_value <= `FLLT_FINE_RST;
		end else if (clk_en_in) begin
			st_ff <= nxt_st;
		end
	end

	assign lnk.cfg         = st_ff.cfg;
	assign lnk.value_write = st_ff.value_write;
	assign lnk.flag_clear  = st_ff.flag_clear;
	assign rdata_out       = st_ff.rdata;
endmodule

`default_nettype wire

// ---- fllt_checker.sv ----
/* fllt_checker: concurrent checks on the link between controller and tuner.
   assumes the testbench instantiates it beside the link, on the system clock. */
`timescale 1ns/100ps
`default_nettype none
`include "fllt_params.svh"

module fllt_checker
	import fllt_pkg::*;
(
	input wire logic                      sys_clk_in,
	input wire logic                      resetn_in,
	input wire fllt_cfg_t                 cfg,
	input wire logic                      value_write,
	input wire logic                      flag_clear,
	input wire logic [`FLLT_COARSE_W-1:0] coarse_tuning_value,
	input wire logic [`FLLT_FINE_W-1:0]   fine_tuning_value,
	input wire logic                      loop_ready_flag,
	input wire logic                      coarse_locked_flag,
	input wire logic                      fine_locked_flag,
	input wire logic                      out_of_bounds_flag,
	input wire logic                      reference_stopped_flag,
	input wire logic                      irq
);
	logic cause;

	// irq is a registered level, so allow it a short lag behind its cause
	assign cause = (coarse_locked_flag & cfg.ie_coarse) | (fine_locked_flag & cfg.ie_fine)
		| (reference_stopped_flag & cfg.ie_refstop);

	default clocking cb @(posedge sys_clk_in);
	endclocking
	default disable iff (!resetn_in);

	a_open_write: assert property (
		value_write && cfg.loop_enable && !cfg.closed_loop_select |-> ##[1:2]
		(coarse_tuning_value == cfg.coarse_tuning_value
		&& fine_tuning_value == cfg.fine_tuning_value))
		else $error("open loop value write not applied");
	a_ready_early: assert property (
		$rose(loop_ready_flag) |-> $past(cfg.loop_enable, 8))
		else $error("ready raised too early");
	a_ready_time: assert property (
		$rose(cfg.loop_enable) |-> ##[8:10] loop_ready_flag)
		else $error("ready not raised in time");
	a_coarse_held: assert property (
		cfg.closed_loop_select && coarse_locked_flag |=> $stable(coarse_tuning_value))
		else $error("coarse moved after coarse lock");
	a_usb_coarse: assert property (
		cfg.usb_recovery_mode && cfg.closed_loop_select && !value_write
		|=> $stable(coarse_tuning_value))
		else $error("coarse moved in usb mode");
	a_fine_order: assert property (
		fine_locked_flag && !cfg.usb_recovery_mode |-> coarse_locked_flag)
		else $error("fine lock without coarse lock");
	a_locks_open: assert property (
		!cfg.closed_loop_select [*3] |-> !coarse_locked_flag && !fine_locked_flag)
		else $error("lock flag set in open loop");
	a_irq_set: assert property (
		cause [*3] |-> irq)
		else $error("irq missing");
	a_irq_clr: assert property (
		!cause [*3] |-> !irq)
		else $error("irq without cause");
	a_oob_keep: assert property (
		out_of_bounds_flag && !flag_clear && cfg.loop_enable |=> out_of_bounds_flag)
		else $error("out of bounds flag dropped");
	a_stop_hold: assert property (
		(reference_stopped_flag && !value_write) [*3] |-> $stable(fine_tuning_value))
		else $error("fine moved with reference stopped");
endmodule

`default_nettype wire

// ---- fllt_tb.sv ----
/* fllt_tb: register-level tests of controller and tuner joined by their link.
   assumes out ticks every cycle and reference ticks every 32 cycles. */
`timescale 1ns/100ps
`default_nettype none
`include "fllt_params.svh"

module fllt_tb;
	import fllt_pkg::*;
	logic        sys_clk  = 1'h0;
	logic        resetn   = 1'h0;
	logic        rtk      = 1'h0;
	logic        stk      = 1'h0;
	logic        ron      = 1'h1;
	logic        son      = 1'h0;
	logic        clk_en   = 1'h1;
	logic        wr       = 1'h0;
	logic        rd       = 1'h0;
	logic [3:0]  addr     = 4'h0;
	logic [31:0] wdata    = 32'h0;
	logic [4:0]  rcnt     = 5'h0;
	logic [31:0] rdata;
	logic        stop_irq;
	int          n_errors = 0;
	int          checked  = 0;
	int          n_pulse  = 0;

	fllt_if lnk ();
	fllt_ctrl i_fllt_ctrl (.sys_clk_in(sys_clk), .resetn_in(resetn), .clk_en_in(clk_en),
		.addr_in(addr), .wdata_in(wdata), .wr_in(wr), .rd_in(rd), .rdata_out(rdata),
		.lnk(lnk.ctrl));
	// short stop count: the 2^16-cycle default would dominate run time
	fllt_tuner #(.REF_STOP_LOG2(6)) i_fllt_tuner (.sys_clk_in(sys_clk), .resetn_in(resetn),
		.clk_en_in(clk_en), .ref_tick_in(rtk), .sof_tick_in(stk), .out_tick_in(1'h1),
		.ref_stop_irq_out(stop_irq), .lnk(lnk.tuner));
	fllt_checker i_fllt_checker (.sys_clk_in(sys_clk), .resetn_in(resetn), .cfg(lnk.cfg),
		.value_write(lnk.value_write), .flag_clear(lnk.flag_clear),
		.coarse_tuning_value(lnk.coarse_tuning_value),
		.fine_tuning_value(lnk.fine_tuning_value), .loop_ready_flag(lnk.loop_ready_flag),
		.coarse_locked_flag(lnk.coarse_locked_flag), .fine_locked_flag(lnk.fine_locked_flag),
		.out_of_bounds_flag(lnk.out_of_bounds_flag),
		.reference_stopped_flag(lnk.reference_stopped_flag), .irq(lnk.irq));

	always #20 sys_clk = ~sys_clk;

	always @(posedge sys_clk) begin
		rcnt <= rcnt + 5'h1;
		rtk <= ron && rcnt == 5'h0;
		stk <= son && rcnt == 5'h0;
		if (stop_irq === 1'h1) begin
			n_pulse <= n_pulse + 1;
		end
	end

	task automatic wr_reg(input logic [3:0] a, input logic [31:0] d);
		@(posedge sys_clk);
		addr <= a;
		wdata <= d;
		wr <= 1'h1;
		@(posedge sys_clk);
		wr <= 1'h0;
	endtask

	task automatic rd_reg(input logic [3:0] a, output logic [31:0] d);
		@(posedge sys_clk);
		addr <= a;
		rd <= 1'h1;
		@(posedge sys_clk);
		rd <= 1'h0;
		#1 d = rdata;
	endtask

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		checked++;
		if (got !== exp) begin
			n_errors++;
			$display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	// polls the status word; bounded so a missing flag cannot hang the run
	task automatic wait_stat(input int b, input logic v);
		logic [31:0] s;
		s = 32'h0;
		for (int i = 0; i < 1000; i++) begin
			rd_reg(4'h3, s);
			if (s[b] === v) break;
		end
		chk({31'h0, s[b]}, {31'h0, v});
	endtask

	task automatic end_sim;
		$display("errors=%0d checks=%0d", n_errors, checked);
		if (n_errors == 0 && checked > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask

	initial begin
		logic [31:0] v;
		logic [31:0] f;
		repeat (10) @(posedge sys_clk);
		resetn <= 1'h1;
		rd_reg(4'h1, v);
		chk({16'h0, v[15:0]}, {16'h0, `FLLT_COARSE_RST, `FLLT_FINE_RST});
		rd_reg(4'h3, v);
		chk(v, 32'h0);
		rd_reg(4'h7, v);
		chk(v, 32'h0);
		wr_reg(4'h0, 32'h1);
		wait_stat(0, 1'h1);
		wr_reg(4'h1, {16'h0, 6'h2a, 10'h155});
		rd_reg(4'h1, v);
		chk({16'h0, v[15:0]}, {16'h0, 6'h2a, 10'h155});
		wr_reg(4'h4, 32'h7);
		wr_reg(4'h2, {1'h0, 5'h4, 2'h0, 8'h40, 16'h0020});
		rd_reg(4'h2, v);
		chk(v, {1'h0, 5'h4, 2'h0, 8'h40, 16'h0020});
		wr_reg(4'h0, 32'h3);
		wr_reg(4'h1, 32'h0);
		rd_reg(4'h1, v);
		chk({26'h0, v[15:10]}, 32'h2a);
		wait_stat(1, 1'h1);
		wait_stat(2, 1'h1);
		wait_stat(5, 1'h1);
		wr_reg(4'h2, {1'h0, 5'h4, 2'h0, 8'h40, 16'h0084});
		wait_stat(3, 1'h1);
		rd_reg(4'h1, v);
		chk({31'h0, v[31]}, 32'h1);
		rd_reg(4'h3, v);
		chk({30'h0, v[2:1]}, 32'h3);
		wr_reg(4'h2, {1'h0, 5'h4, 2'h0, 8'h40, 16'h0020});
		repeat (200) @(posedge sys_clk);
		wr_reg(4'h3, 32'h1);
		rd_reg(4'h3, v);
		chk({31'h0, v[3]}, 32'h0);
		wr_reg(4'h0, 32'h7);
		wr_reg(4'h2, {1'h0, 5'h4, 2'h0, 8'h40, 16'h0010});
		rd_reg(4'h1, f);
		repeat (400) @(posedge sys_clk);
		rd_reg(4'h1, v);
		chk({22'h0, v[9:0]}, {22'h0, f[9:0]});
		clk_en <= 1'h0;
		wr_reg(4'h0, 32'h0);
		repeat (20) @(posedge sys_clk);
		clk_en <= 1'h1;
		rd_reg(4'h0, v);
		chk(v, 32'h7);
		ron <= 1'h0;
		wait_stat(4, 1'h1);
		chk(32'(n_pulse), 32'h1);
		ron <= 1'h1;
		wait_stat(4, 1'h0);
		wr_reg(4'h0, 32'h1);
		wr_reg(4'h2, {1'h0, 5'h4, 2'h0, 8'h40, 16'h0020});
		ron <= 1'h0;
		son <= 1'h1;
		// bypass set on purpose: usb mode must ignore it
		wr_reg(4'h0, 32'h5b);
		wait_stat(2, 1'h1);
		rd_reg(4'h3, v);
		chk({31'h0, v[4]}, 32'h0);
		rd_reg(4'h1, v);
		chk({26'h0, v[15:10]}, 32'h2a);
		wr_reg(4'h0, 32'h1);
		son <= 1'h0;
		ron <= 1'h1;
		wr_reg(4'h2, {1'h0, 5'h4, 2'h0, 8'h40, 16'h0040});
		wr_reg(4'h0, 32'hb);
		repeat (200) @(posedge sys_clk);
		rd_reg(4'h3, v);
		chk({31'h0, v[1]}, 32'h1);
		rd_reg(4'h1, v);
		chk({26'h0, v[15:10]}, 32'h2a);
		wr_reg(4'h0, 32'h1);
		wr_reg(4'h0, 32'h3);
		wait_stat(1, 1'h1);
		rd_reg(4'h1, v);
		chk({31'h0, v[15:10] > 6'h2a}, 32'h1);
		wr_reg(4'h0, 32'h1);
		wr_reg(4'h2, {1'h0, 5'h4, 2'h0, 8'h40, 16'h0021});
		wr_reg(4'h0, 32'h2b);
		repeat (300) @(posedge sys_clk);
		rd_reg(4'h3, v);
		chk({30'h0, v[2:1]}, 32'h1);
		wr_reg(4'h0, 32'h1);
		wr_reg(4'h0, 32'hb);
		wait_stat(2, 1'h1);
		end_sim;
	end

	initial begin
		#(40 * 40000);
		n_errors++;
		end_sim;
	end
endmodule

`default_nettype wire
